// ### shared/osc_tc_pkg.sv
// constants for the oscillator power telecommand decoder
package osc_tc_pkg;

	// packet layout, byte indices from the first header byte
	localparam logic [3:0]  hdr_bytes     = 4'ha;
	localparam logic [3:0]  subtype_idx   = 4'h8;
	localparam logic [3:0]  data_hi_idx   = 4'ha;
	localparam logic [3:0]  data_lo_idx   = 4'hb;
	localparam logic [3:0]  pec_hi_idx    = 4'hc;
	localparam logic [3:0]  last_idx      = 4'hd;
	localparam logic [3:0]  idx_max       = 4'hf;

	// expected header bytes 9..0, byte 0 lowest
	// b0 ver/type/dfh/apid hi, b1 apid lo/category, b2 seq flags/ground bits,
	// b3 seq count low, b4-b5 length, b6 service ver/checksum flag/ack,
	// b7 packet type, b8 subtype (checked apart), b9 pad
	localparam logic [79:0] hdr_expect    = {8'h00, 8'h0b, 8'hc0, 8'h11, 8'h07,
	                                         8'h00, 8'h00, 8'hc0, 8'h7c, 8'h1c};
	localparam logic [79:0] hdr_mask      = {8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
	                                         8'hff, 8'h00, 8'hf8, 8'hff, 8'hff};
	localparam logic [7:0]  subtype_osc   = 8'h0b;

	// packet error control
	localparam logic [15:0] crc_init      = 16'hffff;
	localparam logic [15:0] crc_poly      = 16'h1021;

	// register byte offsets
	localparam logic [7:0]  hk_off        = 8'h00;
	localparam logic [7:0]  cfg_off       = 8'h04;
	localparam logic [7:0]  stat_off      = 8'h08;
	localparam logic [7:0]  ctrl_off      = 8'h64;

	// field positions and reset values
	localparam int          osc_ctrl_bit  = 13;
	localparam int          osc_hk_bit    = 10;
	localparam logic [31:0] ctrl_reset    = 32'h0000_0000;
	localparam logic        enable_reset  = 1'b1;

endpackage : osc_tc_pkg

// ### hdl/tc_crc16.sv
// byte-wide crc-16 engine for the packet error control field
`timescale 1ns/1ps
module tc_crc16 #(
	parameter logic [15:0] POLY = osc_tc_pkg::crc_poly,
	parameter logic [15:0] INIT = osc_tc_pkg::crc_init
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        clear,
	input  wire logic        enable,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc
);

	logic [15:0] crc_reg;
	logic [15:0] base;
	logic [15:0] stepped;

	// msb-first, no reflection, no final xor
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	assign base    = clear ? INIT : crc_reg;
	assign stepped = crc_step(base, data);
	assign crc     = crc_reg;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			crc_reg <= INIT;
		end else if (enable) begin
			crc_reg <= stepped;
		end else if (clear) begin
			crc_reg <= INIT;
		end
	end

endmodule : tc_crc16

// ### hdl/osc_power_telecommand_decoder.sv
// oscillator power telecommand decoder with avalon-mm register slave
//
// Overview of operation
// - packet length field must read seven: data bytes plus five.
// - process id must be 1000111 and category 1100.
// - service version field must be 000, a ground-sourced telecommand.
// - acknowledge field must be 0001, acceptance acknowledgement only.
// - packet type must be 11000000, the private telecommand code.
// - oscillator power command selected only for subtype 00001011.
// - 16-bit application data is the state: 0 off, 1 on.
// - accepted command applied to hardware at once, nothing deferred.
// - requested value written to bit 13 of control register 100, others kept.
// - housekeeping word bit 10 mirrors the oscillator control bit.
// - power-on and patch restart both clear the oscillator bit.
`timescale 1ns/1ps
module osc_power_telecommand_decoder #(
	parameter int CNT_W = 8
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        soft_restart,
	input  wire logic        tc_valid,
	input  wire logic        tc_first,
	input  wire logic        tc_last,
	input  wire logic [7:0]  tc_data,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [31:0] control_register_addr100,
	output logic             reference_oscillator_on,
	output logic      [15:0] housekeeping_status_word
);

	typedef enum logic [1:0] {st_idle, st_recv} rx_state_t;

	if (CNT_W < 1 || CNT_W > 10) begin : g_bad_cnt_w
		$error("CNT_W must lie in 1..10");
	end

	rx_state_t        state_reg;
	rx_state_t        state_next;
	logic [3:0]       idx_reg;
	logic             bad_reg;
	logic             sub_ok_reg;
	logic [15:0]      data_reg;
	logic [7:0]       pec_hi_reg;
	logic [31:0]      ctrl_reg;
	logic [31:0]      ctrl_next;
	logic             enable_reg;
	logic [CNT_W-1:0] acc_cnt_reg;
	logic [CNT_W-1:0] rej_cnt_reg;
	logic [CNT_W-1:0] ign_cnt_reg;
	logic             ack_reg;
	logic [31:0]      rdata_reg;

	logic [3:0]       cur_idx;
	logic [3:0]       hdr_idx;
	logic             byte_take;
	logic             in_hdr;
	logic [7:0]       exp_byte;
	logic [7:0]       mask_byte;
	logic             hdr_bad;
	logic             len_bad;
	logic             byte_bad;
	logic             bad_cur;
	logic             crc_en;
	logic             crc_clr;
	logic [15:0]      crc_val;
	logic             pkt_end;
	logic             pec_ok;
	logic             data_ok;
	logic             pkt_good;
	logic             accept;
	logic             ignored;
	logic             abandon;
	logic             reject;
	logic [3:0]       idx_next;

	// packet byte stream
	assign cur_idx   = tc_first ? 4'h0 : idx_reg;
	assign byte_take = tc_valid & enable_reg & (tc_first | (state_reg == st_recv));
	assign in_hdr    = cur_idx < osc_tc_pkg::hdr_bytes;
	assign hdr_idx   = in_hdr ? cur_idx : 4'h0;
	assign exp_byte  = osc_tc_pkg::hdr_expect[hdr_idx*8 +: 8];
	assign mask_byte = osc_tc_pkg::hdr_mask[hdr_idx*8 +: 8];
	assign hdr_bad   = in_hdr & (((tc_data ^ exp_byte) & mask_byte) != 8'h00);
	assign len_bad   = (cur_idx > osc_tc_pkg::last_idx)
	                 | (tc_last & (cur_idx != osc_tc_pkg::last_idx));
	assign byte_bad  = hdr_bad | len_bad;
	assign bad_cur   = tc_first ? 1'b0 : bad_reg;
	assign idx_next  = (cur_idx == osc_tc_pkg::idx_max) ? cur_idx : cur_idx + 4'h1;

	// checksum runs over every byte before the error control field
	assign crc_clr   = byte_take & tc_first;
	assign crc_en    = byte_take & (cur_idx < osc_tc_pkg::pec_hi_idx);

	tc_crc16 #(
		.POLY   (osc_tc_pkg::crc_poly),
		.INIT   (osc_tc_pkg::crc_init)
	) u_crc (
		.clock  (clock),
		.nrst   (nrst),
		.clear  (crc_clr),
		.enable (crc_en),
		.data   (tc_data),
		.crc    (crc_val)
	);

	// verdict on the closing byte
	assign pkt_end   = byte_take & tc_last;
	assign pec_ok    = {pec_hi_reg, tc_data} == crc_val;
	assign data_ok   = data_reg[15:1] == 15'h0000;
	assign pkt_good  = pkt_end & ~bad_cur & ~byte_bad & pec_ok & data_ok;
	assign accept    = pkt_good & sub_ok_reg;
	assign ignored   = pkt_good & ~sub_ok_reg;
	assign abandon   = byte_take & tc_first & (state_reg == st_recv);
	assign reject    = (pkt_end & ~pkt_good) | abandon;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_idle: begin
				if (byte_take && tc_first && !tc_last) begin
					state_next = st_recv;
				end
			end
			st_recv: begin
				if (pkt_end) begin
					state_next = st_idle;
				end
			end
			default: begin
				state_next = st_idle;
			end
		endcase
		if (soft_restart || !enable_reg) begin
			state_next = st_idle;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= st_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			idx_reg    <= 4'h0;
			bad_reg    <= 1'b0;
			sub_ok_reg <= 1'b0;
			data_reg   <= 16'h0000;
			pec_hi_reg <= 8'h00;
		end else if (byte_take) begin
			idx_reg <= idx_next;
			bad_reg <= bad_cur | byte_bad;
			if (tc_first) begin
				sub_ok_reg <= 1'b0;
			end
			if (cur_idx == osc_tc_pkg::subtype_idx) begin
				sub_ok_reg <= tc_data == osc_tc_pkg::subtype_osc;
			end
			if (cur_idx == osc_tc_pkg::data_hi_idx) begin
				data_reg[15:8] <= tc_data;
			end
			if (cur_idx == osc_tc_pkg::data_lo_idx) begin
				data_reg[7:0] <= tc_data;
			end
			if (cur_idx == osc_tc_pkg::pec_hi_idx) begin
				pec_hi_reg <= tc_data;
			end
		end
	end

	// register slave, one wait state per access
	logic        bus_req;
	logic        bus_wr;
	logic        sel_hk;
	logic        sel_cfg;
	logic        sel_stat;
	logic        sel_ctrl;
	logic [31:0] be_mask;
	logic [31:0] sw_ctrl;
	logic [31:0] stat_word;
	logic [31:0] rd_mux;

	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign bus_wr          = avs_write & ack_reg;
	assign sel_hk          = avs_address == osc_tc_pkg::hk_off;
	assign sel_cfg         = avs_address == osc_tc_pkg::cfg_off;
	assign sel_stat        = avs_address == osc_tc_pkg::stat_off;
	assign sel_ctrl        = avs_address == osc_tc_pkg::ctrl_off;

	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign be_mask[8*i +: 8] = {8{avs_byteenable[i]}};
	end

	assign sw_ctrl   = (bus_wr & sel_ctrl) ? ((ctrl_reg & ~be_mask) | (avs_writedata & be_mask))
	                                       : ctrl_reg;
	assign stat_word = 32'({ign_cnt_reg, rej_cnt_reg, acc_cnt_reg});
	assign rd_mux    = sel_hk   ? {16'h0000, housekeeping_status_word} :
	                   sel_cfg  ? {31'h0000_0000, enable_reg} :
	                   sel_stat ? stat_word :
	                   sel_ctrl ? ctrl_reg : 32'h0000_0000;

	// command wins over a software write to the oscillator bit, restart wins over both
	always_comb begin
		ctrl_next = sw_ctrl;
		if (accept) begin
			ctrl_next[osc_tc_pkg::osc_ctrl_bit] = data_reg[0];
		end
		if (soft_restart) begin
			ctrl_next[osc_tc_pkg::osc_ctrl_bit] = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg   <= osc_tc_pkg::ctrl_reset;
			enable_reg <= osc_tc_pkg::enable_reset;
			ack_reg    <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			ctrl_reg <= ctrl_next;
			ack_reg  <= bus_req & ~ack_reg;
			if (bus_wr && sel_cfg && avs_byteenable[0]) begin
				enable_reg <= avs_writedata[0];
			end
			if (avs_read && !ack_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			acc_cnt_reg <= '0;
			rej_cnt_reg <= '0;
			ign_cnt_reg <= '0;
		end else begin
			acc_cnt_reg <= acc_cnt_reg + CNT_W'(accept);
			rej_cnt_reg <= rej_cnt_reg + CNT_W'(reject);
			ign_cnt_reg <= ign_cnt_reg + CNT_W'(ignored);
		end
	end

	assign avs_readdata             = rdata_reg;
	assign control_register_addr100 = ctrl_reg;
	assign reference_oscillator_on  = ctrl_reg[osc_tc_pkg::osc_ctrl_bit];
	assign housekeeping_status_word = 16'({15'h0000, reference_oscillator_on})
	                                  << osc_tc_pkg::osc_hk_bit;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	accept_sets_bit_a: assert property (
		accept && !soft_restart |=> reference_oscillator_on == $past(data_reg[0]))
		else $error("accepted command did not set the oscillator bit");

	other_bits_kept_a: assert property (
		accept && !bus_wr |=> (ctrl_reg | 32'h0000_2000) == ($past(ctrl_reg) | 32'h0000_2000))
		else $error("command disturbed other control bits");

	apply_cause_a: assert property (
		$changed(reference_oscillator_on) |-> $past(accept || bus_wr || soft_restart))
		else $error("oscillator bit changed without a cause");

	hk_mirror_a: assert property (
		housekeeping_status_word == (16'h0400 & {16{control_register_addr100[13]}}))
		else $error("housekeeping bit 10 does not mirror control bit 13");

	restart_clear_a: assert property (
		soft_restart |=> !reference_oscillator_on)
		else $error("restart did not clear the oscillator bit");

	subtype_only_a: assert property (
		accept |-> sub_ok_reg && cur_idx == osc_tc_pkg::last_idx)
		else $error("accepted a packet with wrong subtype or length");

	bad_pec_a: assert property (
		pkt_end && !pec_ok && !bus_wr && !soft_restart |=> $stable(ctrl_reg)
		##1 ($stable(ctrl_reg) || $past(bus_wr || accept || soft_restart)))
		else $error("packet with bad checksum changed the control register");

	header_bad_a: assert property (
		pkt_end && (bad_cur || hdr_bad) |-> !accept ##1 rej_cnt_reg == $past(rej_cnt_reg) + 1'b1)
		else $error("packet with bad header was not rejected");

	data_value_a: assert property (
		accept |-> data_reg == 16'h0000 || data_reg == 16'h0001)
		else $error("accepted a state value other than 0 or 1");

	bus_answer_a: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not answered after one wait cycle");

endmodule : osc_power_telecommand_decoder

// ### verification/tc_source.sv
// command source model that builds and sends oscillator power packets
`timescale 1ns/1ps
module tc_source (
	input  wire logic       clock,
	output logic            tc_valid,
	output logic            tc_first,
	output logic            tc_last,
	output logic      [7:0] tc_data
);
	logic [10:0] seq_reg = 11'h000;
	logic [7:0]  pkt [14];
	logic [15:0] crc;

	initial begin
		tc_valid = 1'b0;
		tc_first = 1'b0;
		tc_last  = 1'b0;
		tc_data  = 8'h00;
	end

	// one msb-first crc step over a byte
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c  = {c[14:0], 1'b0} ^ (fb ? osc_tc_pkg::crc_poly : 16'h0000);
		end
		return c;
	endfunction : crc_step

	// bad[11:8] byte index, bad[7:0] flip mask; index 12 and up flipped after crc
	task automatic send(input logic [15:0] dat, input logic [11:0] bad);
		pkt = '{8'h1c, 8'h7c, {5'h18, seq_reg[10:8]}, seq_reg[7:0], 8'h00, 8'h07, 8'h11,
		        8'hc0, 8'h0b, 8'h00, dat[15:8], dat[7:0], 8'h00, 8'h00};
		if (bad[11:8] < 4'hc) pkt[bad[11:8]] ^= bad[7:0];
		crc = 16'hffff;
		for (int i = 0; i < 12; i++) crc = crc_step(crc, pkt[i]);
		pkt[12] = crc[15:8];
		pkt[13] = crc[7:0];
		if (bad[11:8] >= 4'hc) pkt[bad[11:8]] ^= bad[7:0];
		seq_reg = seq_reg + 11'h001;
		for (int i = 0; i < 14; i++) begin
			@(posedge clock);
			tc_valid <= 1'b1;
			tc_first <= (i == 0);
			tc_last  <= (i == 13);
			tc_data  <= pkt[i];
		end
		@(posedge clock);
		tc_valid <= 1'b0;
		tc_first <= 1'b0;
		tc_last  <= 1'b0;
		tc_data  <= ~pkt[13];
	endtask : send
endmodule : tc_source

// ### verification/osc_power_telecommand_decoder_tb.sv
// self-checking bench for the oscillator power telecommand decoder
`timescale 1ns/1ps
module osc_power_telecommand_decoder_tb;
	logic        clock;
	logic        nrst;
	logic        soft_restart;
	logic        tc_valid;
	logic        tc_first;
	logic        tc_last;
	logic [7:0]  tc_data;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] ctrl;
	logic        osc_on;
	logic [15:0] hk;
	int          err_count = 0;
	int          n_tests = 0;
	int          cycles = 0;
	// header, crc, subtype and data faults
	logic [11:0] bad_tab [18] = '{12'h080, 12'h010, 12'h008, 12'h140, 12'h101, 12'h280,
	                              12'h220, 12'h480, 12'h501, 12'h680, 12'h610, 12'h601,
	                              12'h780, 12'h801, 12'h901, 12'hb02, 12'hc01, 12'hd10};

	osc_power_telecommand_decoder uut (
		.clock(clock), .nrst(nrst), .soft_restart(soft_restart), .tc_valid(tc_valid),
		.tc_first(tc_first), .tc_last(tc_last), .tc_data(tc_data),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .control_register_addr100(ctrl),
		.reference_oscillator_on(osc_on), .housekeeping_status_word(hk)
	);

	tc_source src (
		.clock(clock), .tc_valid(tc_valid), .tc_first(tc_first), .tc_last(tc_last),
		.tc_data(tc_data)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			close_out;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_out(input logic [31:0] c, input logic o, input logic [15:0] h);
		chk(ctrl, c);
		chk({31'h0, osc_on}, {31'h0, o});
		chk({16'h0, hk}, {16'h0, h});
	endtask : chk_out

	// one avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp);
		logic [31:0] d;
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= ~wr;
		avs_write     <= wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (!wr) chk(d, exp);
	endtask : bus

	initial begin
		nrst          = 1'b0;
		soft_restart  = 1'b0;
		avs_address   = 8'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		#1 chk_out(32'h0, 1'b0, 16'h0000);
		bus(1'b0, osc_tc_pkg::cfg_off, 32'h0, 32'h1);
		bus(1'b0, 8'h10, 32'h0, 32'h0);
		src.send(16'h0001, 12'hd00);
		#1 chk_out(32'h2000, 1'b1, 16'h0400);
		bus(1'b0, osc_tc_pkg::ctrl_off, 32'h0, 32'h2000);
		bus(1'b0, osc_tc_pkg::hk_off, 32'h0, 32'h400);
		bus(1'b1, osc_tc_pkg::ctrl_off, 32'h1234_4321, 32'h0);
		bus(1'b0, osc_tc_pkg::ctrl_off, 32'h0, 32'h1234_4321);
		src.send(16'h0001, 12'hd00);
		#1 chk_out(32'h1234_6321, 1'b1, 16'h0400);
		foreach (bad_tab[k]) begin
			src.send(16'h0000, bad_tab[k]);
			#1 chk_out(32'h1234_6321, 1'b1, 16'h0400);
		end
		src.send(16'h0000, 12'hd00);
		#1 chk_out(32'h1234_4321, 1'b0, 16'h0000);
		src.send(16'h0001, 12'hd00);
		#1 chk_out(32'h1234_6321, 1'b1, 16'h0400);
		@(posedge clock);
		soft_restart <= 1'b1;
		@(posedge clock);
		soft_restart <= 1'b0;
		#1 chk({31'h0, osc_on}, 32'h0);
		chk({16'h0, hk}, 32'h0);
		bus(1'b1, osc_tc_pkg::cfg_off, 32'h0, 32'h0);
		src.send(16'h0001, 12'hd00);
		#1 chk_out(32'h1234_4321, 1'b0, 16'h0000);
		bus(1'b1, osc_tc_pkg::cfg_off, 32'h1, 32'h0);
		src.send(16'h0001, 12'hd00);
		#1 chk_out(32'h1234_6321, 1'b1, 16'h0400);
		bus(1'b0, osc_tc_pkg::stat_off, 32'h0, 32'h0001_1105);
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		#1 chk_out(32'h0, 1'b0, 16'h0000);
		@(posedge clock);
		nrst <= 1'b1;
		bus(1'b0, osc_tc_pkg::ctrl_off, 32'h0, 32'h0);
		close_out;
	end
endmodule : osc_power_telecommand_decoder_tb
